// >>> shared/bcf_pkg.sv
/*
  Shared constants and types for the brushless commutation and fault core.
  Assumes one 200 MHz clock; the PWM period is counted from that clock.
*/
package bcf_pkg;
  // Clock and PWM timing
  localparam int CLK_MHZ = 200;
  localparam int PWM_FREQ_KHZ = 50;
  localparam int PWM_PERIOD_CYC = (CLK_MHZ * 1000) / PWM_FREQ_KHZ;
  localparam int PWM_W = 12;
  localparam int SYNC_STAGES = 2;

  // Per-phase drive state
  typedef enum logic [1:0] {
    BCF_TRI = 2'h0,
    BCF_POS = 2'h1,
    BCF_NEG = 2'h2,
    BCF_LOW = 2'h3
  } bcf_drive_e;

  // Index of the phase whose Hall input is inverted for the 60 pattern
  localparam int HALL_INV_BIT = 1;
  localparam logic [2:0] HALL_INV_MASK = 3'h2;
  localparam logic [1:0] SENSE_NONE = 2'h3;
endpackage

// >>> logic/bcf_sync.sv
/*
  Multi-bit two-flop synchroniser for asynchronous pins.
  Assumes each bit is independent; no bus coherency is implied.
*/
`timescale 1ns/100ps
module bcf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage is read only by the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// >>> logic/bcf_core.sv
/*
  Commutation decoder, PWM generator and protection logic of a three-phase
  brushless bridge driver. Each phase leaves as top and bottom gate enables.
  Assumes analog comparators deliver peak trip, average limit, thermal,
  supply overcurrent and supply-good as asynchronous logic levels, and that
  an external duty value is already digitised.
*/
// What this block does
// - Quadrant select pin picks 2-quadrant or 4-quadrant PWM.
// - In 2-quadrant mode one coil terminal is constant, other switches.
// - In 2-quadrant mode the PWM sits on the positive terminal.
// - In 4-quadrant mode both coil terminals switch with PWM.
// - Reverse pin flips rotation in 2-quadrant mode.
// - Sector select low decodes 60 degree, high decodes 120 degree Hall.
// - Pattern change is done by inverting the second Hall input.
// - Each pattern uses six of eight codes, four of them shared by both.
// - Phase state is PWM high, PWM low, constant low or tri-state.
// - Peak current trip is cleared at each PWM cycle start.
// - Current sense mux picks the phase carrying energised coil current.
// - Thermal trip latches off; clears on output enable after cooling.
// - Supply overcurrent latches off; clears on output enable cycling.
// - Supply loss disables outputs without raising fault.
// - Fault is high whenever outputs are disabled, except by supply loss, including enable low.
// - Output enable low then high clears latched shutdowns.
// - Average limit disables outputs and raises fault, non-latching.
// - Sensor change pulse fires on every decoded Hall change.
// - Switches act only with output enable high, else tri-state.
`timescale 1ns/100ps
module bcf_core import bcf_pkg::*; #(
  parameter int PERIOD = PWM_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Mode pins
  input wire logic quadrant_select,
  input wire logic reverse_cmd_pin,
  input wire logic sector_120_sel,
  input wire logic output_enable,
  // Hall sensors
  input wire logic hall_in_a,
  input wire logic hall_in_b,
  input wire logic hall_in_c,
  // Protection comparators
  input wire logic peak_trip,
  input wire logic avg_limit,
  input wire logic over_temp,
  input wire logic supply_overcurrent,
  input wire logic supply_good,
  // Duty command, counts high per period
  input wire logic [PWM_W-1:0] duty,
  // Phase drives: top and bottom switch enables
  output logic [2:0] phase_top_on,
  output logic [2:0] phase_bot_on,
  output logic [1:0] phase_drive_a,
  output logic [1:0] phase_drive_b,
  output logic [1:0] phase_drive_c,
  // Status
  output logic [1:0] sense_select,
  output logic sensor_change_pulse,
  output logic fault
);
  localparam int NSYNC = 11;
  localparam logic [PWM_W-1:0] PERIOD_LAST = PWM_W'(PERIOD - 1);

  logic [NSYNC-1:0] pins_s;
  logic q2_s, rev_s, s120_s, oe_s, peak_s, avg_s, temp_s, ocp_s, good_s;
  logic [2:0] hall_s;

  bcf_sync #(.WIDTH(NSYNC)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in({quadrant_select, reverse_cmd_pin, sector_120_sel, output_enable,
               hall_in_c, hall_in_b, hall_in_a, peak_trip, avg_limit, over_temp,
               supply_overcurrent}),
    .sync_out(pins_s)
  );

  logic good_m_q, good_q;
  // Supply-good goes through its own pair so the shared sync stays compact
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      good_m_q <= 1'b0;
      good_q <= 1'b0;
    end else begin
      good_m_q <= supply_good;
      good_q <= good_m_q;
    end
  end

  assign {q2_s, rev_s, s120_s, oe_s} = pins_s[10:7];
  // Sensor a is the top bit of the code, sensor c the bottom bit
  assign hall_s = {pins_s[4], pins_s[5], pins_s[6]};
  assign {peak_s, avg_s, temp_s, ocp_s} = pins_s[3:0];
  assign good_s = good_q;

  // Invert second Hall input in 60 degree mode
  logic [2:0] code;
  always_comb begin
    code = hall_s ^ (s120_s ? 3'h0 : HALL_INV_MASK);
  end

  // Forward lookup on 120 degree codes; 000 and 111 invalid
  bcf_drive_e fwd [3];
  logic [1:0] sense_raw;
  logic valid;
  always_comb begin
    fwd[0] = BCF_TRI;
    fwd[1] = BCF_TRI;
    fwd[2] = BCF_TRI;
    valid = 1'b1;
    case (code)
      3'h5: begin fwd[0] = BCF_TRI; fwd[1] = BCF_NEG; fwd[2] = BCF_POS; end
      3'h4: begin fwd[0] = BCF_POS; fwd[1] = BCF_NEG; fwd[2] = BCF_TRI; end
      3'h6: begin fwd[0] = BCF_POS; fwd[1] = BCF_TRI; fwd[2] = BCF_NEG; end
      3'h2: begin fwd[0] = BCF_TRI; fwd[1] = BCF_POS; fwd[2] = BCF_NEG; end
      3'h3: begin fwd[0] = BCF_NEG; fwd[1] = BCF_POS; fwd[2] = BCF_TRI; end
      3'h1: begin fwd[0] = BCF_NEG; fwd[1] = BCF_TRI; fwd[2] = BCF_POS; end
      default: valid = 1'b0;
    endcase
  end

  // Reverse swaps positive and negative terminals in 2-quadrant mode
  // Reverse is honoured only in 2-quadrant mode; ignored otherwise
  bcf_drive_e cmd [3];
  logic rev_eff;
  assign rev_eff = q2_s & rev_s;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cmd[i] = fwd[i];
      if (rev_eff && fwd[i] == BCF_POS) cmd[i] = BCF_NEG;
      else if (rev_eff && fwd[i] == BCF_NEG) cmd[i] = BCF_POS;
      if (q2_s && cmd[i] == BCF_NEG) cmd[i] = BCF_LOW;
    end
  end

  // Sense the phase driven low, which carries coil return current
  always_comb begin
    sense_raw = SENSE_NONE;
    for (int i = 0; i < 3; i++) begin
      if (valid && (cmd[i] == BCF_NEG || cmd[i] == BCF_LOW)) sense_raw = 2'(i);
    end
  end

  // PWM counter, restarts each period
  logic [PWM_W-1:0] cnt_q, cnt_d;
  logic cycle_start, pwm_on;
  always_comb begin
    cycle_start = (cnt_q == PERIOD_LAST);
    cnt_d = cycle_start ? '0 : cnt_q + 1'b1;
    pwm_on = (cnt_q < duty);
  end

  // Protection state
  logic peak_q, peak_d, temp_q, temp_d, ocp_q, ocp_d, oe_prev_q, oe_prev_d;
  logic oe_rise, enabled, fault_d, fault_q;
  always_comb begin
    oe_rise = oe_s & ~oe_prev_q;
    oe_prev_d = oe_s;
    // Peak trip holds for the rest of the cycle only; set wins
    peak_d = peak_s | (peak_q & ~cycle_start);
    // Thermal latch clears on enable rise once cool
    temp_d = temp_s | (temp_q & ~oe_rise);
    // Overcurrent latch clears on enable low-high cycle
    ocp_d = ocp_s | (ocp_q & ~oe_rise);
    // Enable gate; supply loss has no fault
    enabled = oe_s & good_s & ~temp_q & ~ocp_q & ~avg_s;
    // Fault whenever disabled except by supply loss
    fault_d = ~oe_s | temp_q | ocp_q | avg_s;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      peak_q <= 1'b0;
      temp_q <= 1'b0;
      ocp_q <= 1'b0;
      oe_prev_q <= 1'b0;
      fault_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      peak_q <= peak_d;
      temp_q <= temp_d;
      ocp_q <= ocp_d;
      oe_prev_q <= oe_prev_d;
      fault_q <= fault_d;
    end
  end

  // Gate generation: POS is top on during PWM high, bottom otherwise
  logic [2:0] top_d, bot_d, top_q, bot_q;
  logic [5:0] drv_d, drv_q;
  logic conduct;
  assign conduct = pwm_on & ~peak_q;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      top_d[i] = 1'b0;
      bot_d[i] = 1'b0;
      drv_d[2*i +: 2] = BCF_TRI;
      if (enabled && valid) begin
        drv_d[2*i +: 2] = cmd[i];
        case (cmd[i])
          BCF_POS: begin top_d[i] = conduct; bot_d[i] = ~conduct; end
          BCF_NEG: begin top_d[i] = ~conduct; bot_d[i] = conduct; end
          BCF_LOW: bot_d[i] = 1'b1;
          default: ;
        endcase
      end
    end
  end

  // Change pulse on decoded code change
  logic [2:0] code_q;
  logic chg_q, chg_d;
  logic [1:0] sense_q;
  always_comb begin
    chg_d = (code != code_q);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      top_q <= '0;
      bot_q <= '0;
      drv_q <= '0;
      // Matches the code decoded from the reset synchroniser, so reset gives no false pulse
      code_q <= HALL_INV_MASK;
      chg_q <= 1'b0;
      sense_q <= SENSE_NONE;
    end else begin
      top_q <= top_d;
      bot_q <= bot_d;
      drv_q <= drv_d;
      code_q <= code;
      chg_q <= chg_d;
      sense_q <= sense_raw;
    end
  end

  assign phase_top_on = top_q;
  assign phase_bot_on = bot_q;
  assign phase_drive_a = drv_q[1:0];
  assign phase_drive_b = drv_q[3:2];
  assign phase_drive_c = drv_q[5:4];
  assign sense_select = sense_q;
  assign sensor_change_pulse = chg_q;
  assign fault = fault_q;
endmodule

// >>> testbench/bcf_motor.sv
/* Hall sensor model of a turning three-phase motor.
   Assumes the bench sets pos in 0..5 and glitch for broken sensors. */
`timescale 1ns/100ps
module bcf_motor import bcf_pkg::*; (
  // Rotor
  input wire logic [2:0] pos,
  input wire logic sector_120_sel,
  input wire logic [1:0] glitch,
  // Hall lines
  output logic hall_in_a,
  output logic hall_in_b,
  output logic hall_in_c
);
  localparam logic [2:0] SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  // 60 degree sensors differ in the second line
  // Codes read {a,b,c}, position 0 first
  always_comb begin
    {hall_in_a, hall_in_b, hall_in_c} = SEQ[pos] ^ (sector_120_sel ? 3'h0 : HALL_INV_MASK);
    if (glitch != 2'h0) begin
      {hall_in_c, hall_in_b, hall_in_a} = {3{glitch[1]}}; // Dead sensors
    end
  end
endmodule

// >>> testbench/bcf_core_chk.sv
/* Timing checks on the core ports.
   Assumes the single clock domain and the latencies of the hand-over. */
`timescale 1ns/100ps
module bcf_core_chk import bcf_pkg::*; (
  // Watched ports
  input wire logic clock,
  input wire logic rst_b,
  input wire logic quadrant_select,
  input wire logic reverse_cmd_pin,
  input wire logic sector_120_sel,
  input wire logic output_enable,
  input wire logic hall_in_a,
  input wire logic hall_in_b,
  input wire logic hall_in_c,
  input wire logic avg_limit,
  input wire logic over_temp,
  input wire logic supply_overcurrent,
  input wire logic supply_good,
  input wire logic [2:0] phase_top_on,
  input wire logic [2:0] phase_bot_on,
  input wire logic [1:0] phase_drive_a,
  input wire logic [1:0] phase_drive_b,
  input wire logic [1:0] phase_drive_c,
  input wire logic sensor_change_pulse,
  input wire logic fault
);
  // Sampling on the rising edge, quiet in reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_oe_low_fault: assert property ($fell(output_enable) |-> ##[1:5] fault) else $error("fault late");
  a_oe_off_tri: assert property (!output_enable [*6] |-> (phase_top_on | phase_bot_on) == 3'h0)
    else $error("bridge on");
  a_avg_fault: assert property (avg_limit [*5] |-> fault) else $error("limit no fault");
  a_temp_latch: assert property (over_temp && output_enable ##1 output_enable [*8] |-> fault)
    else $error("thermal not held");
  a_soc_latch: assert property (supply_overcurrent && output_enable ##1 output_enable [*8] |-> fault)
    else $error("overcurrent not held");
  a_hall_pulse: assert property ($changed({hall_in_c, hall_in_b, hall_in_a}) && $stable(sector_120_sel)
    |-> ##[2:5] sensor_change_pulse) else $error("no change pulse");
  a_two_q_low: assert property ((quadrant_select && !reverse_cmd_pin && sector_120_sel && !fault
    && supply_good && {hall_in_c, hall_in_b, hall_in_a} == 3'h5) [*6]
    |-> phase_drive_b == BCF_LOW && phase_drive_c == BCF_POS)
    else $error("2q pattern");
  a_bad_tri: assert property ((sector_120_sel && {hall_in_c, hall_in_b, hall_in_a} == 3'h7) [*6]
    |-> {phase_drive_c, phase_drive_b, phase_drive_a} == 6'h00) else $error("bad code drives");
  a_supply_quiet: assert property ((!supply_good && output_enable && !avg_limit) [*6]
    |-> !fault && (phase_top_on | phase_bot_on) == 3'h0) else $error("supply loss");
endmodule
bind bcf_core bcf_core_chk bcf_core_chk_i (.*);

// >>> testbench/bcf_core_tb.sv
/* Self-checking bench for the commutation and fault core.
   Assumes a 16 cycle PWM period and the motor model for the Hall lines. */
`timescale 1ns/100ps
module bcf_core_tb import bcf_pkg::*; ();
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic quadrant_select = 1'h0, reverse_cmd_pin = 1'h0, sector_120_sel = 1'h1;
  logic output_enable = 1'h1, avg_limit = 1'h0, over_temp = 1'h0, supply_overcurrent = 1'h0, supply_good = 1'h1;
  logic peak_trip = 1'h0;
  logic hall_in_a, hall_in_b, hall_in_c, sensor_change_pulse, fault;
  logic [2:0] pos = 3'h5;
  logic [1:0] glitch = 2'h0;
  logic [2:0] phase_top_on, phase_bot_on;
  logic [1:0] phase_drive_a, phase_drive_b, phase_drive_c, sense_select;
  int err_total = 0;
  int cmp_count = 0;
  // Forward drives {c,b,a}: 0 tri, 1 plus, 2 minus
  localparam logic [5:0] FWD [6] = '{6'h18, 6'h09, 6'h21, 6'h24, 6'h06, 6'h12};
  always #2.5 clock = ~clock;
  bcf_motor bcf_motor_i (.pos(pos), .sector_120_sel(sector_120_sel), .glitch(glitch),
    .hall_in_a(hall_in_a), .hall_in_b(hall_in_b), .hall_in_c(hall_in_c));
  // Duty tied at half period: short period keeps the run brief
  bcf_core #(.PERIOD(16)) bcf_core_i (.clock(clock), .rst_b(rst_b), .quadrant_select(quadrant_select),
    .reverse_cmd_pin(reverse_cmd_pin), .sector_120_sel(sector_120_sel), .output_enable(output_enable),
    .hall_in_a(hall_in_a), .hall_in_b(hall_in_b), .hall_in_c(hall_in_c), .peak_trip(peak_trip),
    .avg_limit(avg_limit), .over_temp(over_temp), .supply_overcurrent(supply_overcurrent),
    .supply_good(supply_good), .duty(12'h008), .phase_top_on(phase_top_on), .phase_bot_on(phase_bot_on),
    .phase_drive_a(phase_drive_a), .phase_drive_b(phase_drive_b), .phase_drive_c(phase_drive_c),
    .sense_select(sense_select), .sensor_change_pulse(sensor_change_pulse), .fault(fault));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Reverse swaps plus and minus, 2-quadrant makes minus constant low
  function automatic logic [5:0] exp_drv(input int p, input logic q2, input logic rv);
    logic [5:0] r;
    r = FWD[p];
    for (int k = 0; k < 6; k += 2) begin
      if (rv && r[k+:2] != 2'h0) r[k+:2] = ~r[k+:2];
      if (q2 && r[k+:2] == 2'h2) r[k+:2] = 2'h3;
    end
    return r;
  endfunction
  // Four mode settings (reverse only in 2-quadrant 60 degree), every rotor step; the pulse wait is bounded
  task automatic t_table();
    int i;
    for (int m = 0; m < 4; m++) begin
      @(posedge clock);
      sector_120_sel <= (m % 2) == 0;
      quadrant_select <= m >= 2;
      reverse_cmd_pin <= m == 3;
      cyc(8);
      for (int p = 0; p < 6; p++) begin
        @(posedge clock);
        pos <= p[2:0];
        // Look first at a settled falling edge, never in the launching time step
        cyc(1);
        for (i = 0; i < 10 && sensor_change_pulse !== 1'h1; i++) @(negedge clock);
        chk({7'h00, sensor_change_pulse}, 8'h01);
        if (i == 10) complete_run();
        cyc(3);
        chk({2'h0, phase_drive_c, phase_drive_b, phase_drive_a}, {2'h0, exp_drv(p, m >= 2, m == 3)});
        if (m == 0 && p == 0) chk({6'h00, sense_select}, 8'h01);
      end
    end
  endtask
  task automatic t_bad();
    @(posedge clock);
    sector_120_sel <= 1'h1;
    glitch <= 2'h1;
    cyc(8);
    chk({2'h0, phase_drive_c, phase_drive_b, phase_drive_a}, 8'h00);
    @(posedge clock);
    glitch <= 2'h2;
    cyc(8);
    chk({2'h0, phase_drive_c, phase_drive_b, phase_drive_a}, 8'h00);
    @(posedge clock);
    glitch <= 2'h0;
    cyc(8);
  endtask
  // Bits: enable, average limit, thermal, supply overcurrent, supply good
  task automatic drv(input logic [4:0] v);
    @(posedge clock);
    {output_enable, avg_limit, over_temp, supply_overcurrent, supply_good} <= v;
    cyc(8);
  endtask
  task automatic t_fault();
    drv(5'h01);
    chk({7'h00, fault}, 8'h01);
    chk({2'h0, phase_top_on, phase_bot_on}, 8'h00);
    drv(5'h11);
    chk({7'h00, fault}, 8'h00);
    drv(5'h19);
    chk({7'h00, fault}, 8'h01);
    drv(5'h11);
    chk({7'h00, fault}, 8'h00);
    drv(5'h15);
    drv(5'h11);
    chk({7'h00, fault}, 8'h01);
    drv(5'h01);
    drv(5'h11);
    chk({7'h00, fault}, 8'h00);
    drv(5'h13);
    drv(5'h11);
    chk({7'h00, fault}, 8'h01);
    drv(5'h01);
    drv(5'h11);
    chk({7'h00, fault}, 8'h00);
    drv(5'h10);
    chk({1'h0, fault, phase_top_on, phase_bot_on}, 8'h00);
    drv(5'h11);
  endtask
  // High cycles of the b and c gates over one 16 cycle PWM period
  task automatic gate_cnt(output logic [7:0] ct, output logic [7:0] cb, output logic [7:0] bt,
    output logic [7:0] bb);
    ct = 8'h00;
    cb = 8'h00;
    bt = 8'h00;
    bb = 8'h00;
    repeat (16) begin
      @(negedge clock);
      ct = ct + 8'(phase_top_on[2]);
      cb = cb + 8'(phase_bot_on[2]);
      bt = bt + 8'(phase_top_on[1]);
      bb = bb + 8'(phase_bot_on[1]);
    end
  endtask
  // Rotor at 0 degrees: c is the positive terminal, b the negative one, duty is half
  task automatic t_pwm();
    logic [7:0] ct, cb, bt, bb;
    @(posedge clock);
    {quadrant_select, reverse_cmd_pin, sector_120_sel} <= 3'h1;
    pos <= 3'h0;
    cyc(8);
    gate_cnt(ct, cb, bt, bb);
    chk(ct, 8'h08);
    chk(cb, 8'h08);
    chk(bt, 8'h08);
    chk(bb, 8'h08);
    @(posedge clock);
    quadrant_select <= 1'h1;
    cyc(8);
    gate_cnt(ct, cb, bt, bb);
    chk(ct, 8'h08);
    chk(bt, 8'h00);
    chk(bb, 8'h10);
    // A held trip ends conduction in every period
    @(posedge clock);
    peak_trip <= 1'h1;
    cyc(8);
    gate_cnt(ct, cb, bt, bb);
    chk(ct, 8'h00);
    chk({7'h00, fault}, 8'h00);
    // Released trip is gone once a new period starts
    @(posedge clock);
    peak_trip <= 1'h0;
    cyc(24);
    gate_cnt(ct, cb, bt, bb);
    chk(ct, 8'h08);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'h1;
    cyc(4);
    t_table();
    t_bad();
    t_fault();
    t_pwm();
    complete_run();
  end
endmodule
